// *** design/dhc_pkg.sv ***
// Purpose: Shared constants and carriers for the debug port hardware-command unit
// Assumes: 100 MHz system clock
// Notes:   Opcodes, timing and command carriers live here
`default_nettype none
package dhc_pkg;

    // Command opcodes
    localparam logic [7:0] DHC_OP_HALT       = 8'h90;
    localparam logic [7:0] DHC_OP_ACK_ON     = 8'hd5;
    localparam logic [7:0] DHC_OP_ACK_OFF    = 8'hd6;
    localparam logic [7:0] DHC_OP_DS_BFETCH  = 8'he4;
    localparam logic [7:0] DHC_OP_DS_WFETCH  = 8'hec;
    localparam logic [7:0] DHC_OP_MEM_BFETCH = 8'he0;
    localparam logic [7:0] DHC_OP_MEM_WFETCH = 8'he8;
    localparam logic [7:0] DHC_OP_DS_BSTORE  = 8'hc4;
    localparam logic [7:0] DHC_OP_DS_WSTORE  = 8'hcc;
    localparam logic [7:0] DHC_OP_MEM_BSTORE = 8'hc0;

    // Idle-cycle wait before the CPU is frozen, in clock cycles
    localparam int         DHC_IDLE_WAIT     = 128;
    localparam logic [7:0] DHC_IDLE_WAIT_W   = 8'(DHC_IDLE_WAIT - 1);

    // Byte lane masks
    localparam logic [1:0] DHC_LANE_HI       = 2'h2;
    localparam logic [1:0] DHC_LANE_LO       = 2'h1;
    localparam logic [1:0] DHC_LANE_BOTH     = 2'h3;

    // Opcode and address bit positions used by the decode
    localparam int         DHC_OPB_FETCH     = 5; // Set for fetches, clear for stores
    localparam int         DHC_OPB_WORD      = 3; // Word-wide access
    localparam int         DHC_OPB_DS        = 2; // Debug register space
    localparam int         DHC_ADDR_ODD      = 0; // Address bit that picks the lane

    // Decoded command from the serial front end
    typedef struct packed {
        logic [7:0]  opcode;
        logic [15:0] addr;
        logic [15:0] wdata;
    } dhc_cmd_t;

    // One system bus access
    typedef struct packed {
        logic        write;
        logic        dbg_space;
        logic [1:0]  lanes;
        logic [15:0] addr;
        logic [15:0] wdata;
    } dhc_bus_req_t;

endpackage : dhc_pkg

`default_nettype wire

// *** design/dhc_unit.sv ***
// Purpose: Executes decoded hardware commands of the single-wire debug port
// Assumes: Serial deframing is outside; commands arrive as a valid pulse
// Notes:   Steals idle bus cycles, freezes CPU when needed, drives ack request
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// RQ1: Wait 128 cycles for idle, then freeze
// RQ2: Single-cycle access in idle cycle never freezes
// RQ3: Multi-cycle access keeps CPU frozen throughout
// RQ4: Commands run in and out of halt
// RQ5: Debug space mapped only during its cycle
// RQ6: E4/EC fetch from debug register space
// RQ7: E0/E8 fetch from system memory
// RQ8: 90 halts if firmware enabled; ack after
// RQ9: D5 enables handshake, then acks
// RQ10: D6 disables handshake, no ack
// RQ11: C4 stores byte with debug space in
// RQ12: CC word store, host gives aligned address
// RQ13: C0 stores byte with debug space out
// RQ14: Odd address low byte, even high byte
// RQ15: Resync discards partial command, soft reset
// RQ16: After resync, next edge starts anew
// RQ17: Resync also cancels pending ack
// RQ18: Badly received command gets no ack
// RQ19: Host treats missing ack as failure
module dhc_unit #(
    parameter int WAIT_CYCLES = dhc_pkg::DHC_IDLE_WAIT
) (
    // Clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_nrst,
    // Command from serial front end
    input  wire logic                  i_cmd_valid,
    input  wire logic                  i_cmd_err,
    input  wire dhc_pkg::dhc_cmd_t     i_cmd,
    input  wire logic                  i_resync,
    output logic                       o_busy,
    output logic                       o_rdata_valid,
    output logic [15:0]                o_rdata,
    output logic                       o_ack_req,
    output logic                       o_ack_en,
    // CPU and bus arbitration
    input  wire logic                  i_bus_idle,
    input  wire logic                  i_fw_enabled,
    input  wire logic                  i_halted,
    output logic                       o_halt_req,
    output logic                       o_cpu_freeze,
    // System bus master port
    output logic                       o_bus_valid,
    output dhc_pkg::dhc_bus_req_t      o_bus_req,
    input  wire logic                  i_bus_done,
    input  wire logic                  i_bus_multi,
    input  wire logic [15:0]           i_bus_rdata
);
    import dhc_pkg::*;

    // Elaboration check; the seek counter is eight bits wide
    if (WAIT_CYCLES < 1 || WAIT_CYCLES > 256)
    begin : g_bad_wait
        $error("WAIT_CYCLES must be 1..256");
    end

    localparam logic [7:0] WAIT_LAST = 8'(WAIT_CYCLES - 1);

    // One-hot states keep each state test to a single bit
    typedef enum logic [4:0] {
        DHC_IDLE   = 5'h01,
        DHC_SEEK   = 5'h02,
        DHC_ACCESS = 5'h04,
        DHC_HALTW  = 5'h08,
        DHC_DONE   = 5'h10
    } dhc_state_t;

    // Byte lane from address parity
    function automatic logic [1:0] byte_lanes(input logic [15:0] a);
        byte_lanes = a[DHC_ADDR_ODD] ? DHC_LANE_LO : DHC_LANE_HI; // [RQ14]
    endfunction : byte_lanes

    function automatic logic is_access(input logic [7:0] op);
        is_access = (op == DHC_OP_DS_BFETCH) || (op == DHC_OP_DS_WFETCH) ||
                    (op == DHC_OP_MEM_BFETCH) || (op == DHC_OP_MEM_WFETCH) ||
                    (op == DHC_OP_DS_BSTORE) || (op == DHC_OP_DS_WSTORE) ||
                    (op == DHC_OP_MEM_BSTORE);
    endfunction : is_access

    // Stores have the fetch bit clear
    function automatic logic op_is_store(input logic [7:0] op);
        op_is_store = !op[DHC_OPB_FETCH];
    endfunction : op_is_store

    // Debug register space select [RQ5]
    function automatic logic op_is_debug(input logic [7:0] op);
        op_is_debug = op[DHC_OPB_DS];
    endfunction : op_is_debug

    // Word-wide forms use both lanes
    function automatic logic op_is_word(input logic [7:0] op);
        op_is_word = op[DHC_OPB_WORD];
    endfunction : op_is_word

    // Registered state and helper decodes
    dhc_state_t   state_q;
    dhc_bus_req_t req_q;
    logic [7:0]   wait_q;
    logic         frz_q;
    logic         ack_en_q;
    logic         halt_q;
    logic [15:0]  rdata_q;
    logic         rvalid_q;
    logic         ackreq_q;
    logic         ack_due_q;
    logic         is_read;
    logic         grant;
    logic         take;
    logic         ds_map_q;

    // Fetch commands return data; stores only write
    assign is_read = ~req_q.write;
    // Idle cycle found, or CPU already frozen so the cycle is ours
    assign grant   = i_bus_idle | frz_q;
    // Command taken: idle, valid and cleanly received [RQ18]
    assign take    = (state_q == DHC_IDLE) && i_cmd_valid && !i_cmd_err;

    // Command sequencer; resync wins over everything [RQ15] [RQ16] [RQ17]
    // Errored commands are never taken, so they cannot earn an ack
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            state_q <= DHC_IDLE;
        else if (i_resync)
            state_q <= DHC_IDLE; // [RQ15]
        else
        begin
            case (state_q)
                DHC_IDLE:
                    if (i_cmd_valid && !i_cmd_err) // [RQ4] [RQ18]
                    begin
                        if (is_access(i_cmd.opcode))
                            state_q <= DHC_SEEK;
                        else if (i_cmd.opcode == DHC_OP_HALT && i_fw_enabled)
                            state_q <= DHC_HALTW; // [RQ8]
                        else
                            state_q <= DHC_DONE;
                    end
                DHC_SEEK:
                    if (grant)
                        state_q <= DHC_ACCESS;
                DHC_ACCESS:
                    if (i_bus_done)
                        state_q <= DHC_DONE;
                DHC_HALTW:
                    if (i_halted)
                        state_q <= DHC_DONE;
                DHC_DONE:
                    state_q <= DHC_IDLE;
                default:
                    state_q <= DHC_IDLE;
            endcase
        end
    end

    // Latch the bus request when a command is taken
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            req_q <= '0;
        else if (take)
        begin
            req_q.addr  <= i_cmd.addr;
            req_q.wdata <= i_cmd.wdata;
            req_q.write <= op_is_store(i_cmd.opcode); // Cx stores, Ex fetches
            // Debug space only for E4/EC/C4/CC [RQ6] [RQ7] [RQ11] [RQ13]
            req_q.dbg_space <= op_is_debug(i_cmd.opcode);
            // Word forms use both lanes; host aligns CC [RQ12]
            req_q.lanes <= op_is_word(i_cmd.opcode) ? DHC_LANE_BOTH
                                                    : byte_lanes(i_cmd.addr); // [RQ14]
        end
    end

    // Idle-cycle search counter; freeze after the wait expires [RQ1]
    // Saturates at the last count so a long stall cannot wrap it
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            wait_q <= '0;
        else if (state_q != DHC_SEEK || i_resync)
            wait_q <= '0;
        else if (wait_q != WAIT_LAST)
            wait_q <= wait_q + 8'h01;
    end

    // CPU freeze: on timeout, or for a multi-cycle access [RQ1] [RQ2] [RQ3]
    // Dropped in DONE so the CPU resumes right after the access
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            frz_q <= 1'b0;
        else if (i_resync || state_q == DHC_IDLE || state_q == DHC_DONE)
            frz_q <= 1'b0;
        else if (state_q == DHC_SEEK && wait_q == WAIT_LAST && !i_bus_idle)
            frz_q <= 1'b1; // [RQ1]
        else if (state_q == DHC_ACCESS && i_bus_multi && !i_bus_done)
            frz_q <= 1'b1; // [RQ3]
    end

    // Handshake enable flag [RQ9] [RQ10]
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            ack_en_q <= 1'b0;
        else if (take && !i_resync)
        begin
            if (i_cmd.opcode == DHC_OP_ACK_ON)
                ack_en_q <= 1'b1; // [RQ9]
            else if (i_cmd.opcode == DHC_OP_ACK_OFF)
                ack_en_q <= 1'b0; // [RQ10]
        end
    end

    // Whether the command in flight earns an ack
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            ack_due_q <= 1'b0;
        else if (i_resync)
            ack_due_q <= 1'b0; // [RQ17]
        else if (state_q == DHC_IDLE && i_cmd_valid)
            // Ack off and errored commands never ack; halt only if it will run
            ack_due_q <= !i_cmd_err && i_cmd.opcode != DHC_OP_ACK_OFF && // [RQ10] [RQ18]
                         (i_cmd.opcode != DHC_OP_HALT || i_fw_enabled); // [RQ8]
    end

    // Halt request held until the CPU reports halt [RQ8]
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            halt_q <= 1'b0;
        else if (i_resync || i_halted)
            halt_q <= 1'b0;
        else if (take && i_cmd.opcode == DHC_OP_HALT && i_fw_enabled)
            halt_q <= 1'b1; // [RQ8]
    end

    // Read data capture
    // Data holds until the next fetch; the valid flag lasts one cycle
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            rdata_q  <= '0;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rvalid_q <= 1'b0;
            if (!i_resync && state_q == DHC_ACCESS && i_bus_done && is_read)
            begin
                rdata_q  <= i_bus_rdata; // [RQ6] [RQ7]
                rvalid_q <= 1'b1;
            end
        end
    end

    // Ack pulse request at completion, only with handshake on [RQ9] [RQ8]
    // Registered so the pulse cannot glitch; one cycle late is harmless
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            ackreq_q <= 1'b0;
        else
            ackreq_q <= !i_resync && state_q == DHC_DONE && ack_due_q && ack_en_q;
    end

    // Debug map select from a flop, set exactly while in ACCESS [RQ5]
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            ds_map_q <= 1'b0;
        else if (i_resync)
            ds_map_q <= 1'b0;
        else if (state_q == DHC_SEEK && grant)
            ds_map_q <= req_q.dbg_space; // [RQ5]
        else if (state_q == DHC_ACCESS && i_bus_done)
            ds_map_q <= 1'b0;
    end

    // Bus strobe only in the access state; debug space mapped just then [RQ5]
    assign o_bus_valid   = (state_q == DHC_ACCESS);
    always_comb
    begin
        o_bus_req           = req_q;
        o_bus_req.dbg_space = ds_map_q; // [RQ5]
    end

    // Freeze output: also the first steal cycle after timeout [RQ1] [RQ2]
    assign o_cpu_freeze  = frz_q;
    // Status and data outputs come straight from flops; busy is decoded from the state
    assign o_halt_req    = halt_q;
    assign o_busy        = (state_q != DHC_IDLE);
    assign o_rdata       = rdata_q;
    assign o_rdata_valid = rvalid_q;
    assign o_ack_req     = ackreq_q;
    assign o_ack_en      = ack_en_q;

endmodule : dhc_unit

`default_nettype wire

// *** test/dhc_unit_monitor.sv ***
// Purpose: Port checks for the hardware-command unit
// Assumes: One clock, async active-low reset
// Notes:   Bound onto dhc_unit
`timescale 1ns/1ps
`default_nettype none
module dhc_unit_monitor #(
    parameter int WAIT_CYCLES = 128
) (
    // Clock, reset, command side
    input wire logic                  i_clk,
    input wire logic                  i_nrst,
    input wire logic                  i_cmd_valid,
    input wire logic                  i_cmd_err,
    input wire logic                  i_resync,
    input wire logic                  o_busy,
    input wire logic                  o_rdata_valid,
    input wire logic [15:0]           o_rdata,
    input wire logic                  o_ack_req,
    input wire logic                  o_ack_en,
    input wire logic                  o_cpu_freeze,
    // Bus side
    input wire logic                  o_bus_valid,
    input wire dhc_pkg::dhc_bus_req_t o_bus_req,
    input wire logic                  i_bus_done,
    input wire logic                  i_bus_multi,
    input wire logic [15:0]           i_bus_rdata
);
    import dhc_pkg::*;
    // Slack covers seek, freeze and access stages
    localparam int WMAX = WAIT_CYCLES + 4;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    a_seek_bounded: assert property ($rose(o_busy) |-> ##[1:WMAX] (o_bus_valid || !o_busy))
        else $error("access not started in time");
    a_idle_no_freeze: assert property (!o_cpu_freeze && $rose(o_bus_valid) && i_bus_done
        && !i_bus_multi |=> !o_cpu_freeze) else $error("single access froze cpu");
    a_multi_freeze: assert property (o_bus_valid && i_bus_multi && !i_bus_done && !i_resync
        |=> o_cpu_freeze) else $error("multi access not frozen");
    a_space_mapped: assert property (!o_bus_valid |-> !o_bus_req.dbg_space)
        else $error("debug space mapped outside access");
    a_byte_lane: assert property (o_bus_valid && o_bus_req.lanes != DHC_LANE_BOTH
        |-> o_bus_req.lanes == (o_bus_req.addr[0] ? DHC_LANE_LO : DHC_LANE_HI))
        else $error("wrong byte lane");
    a_read_data: assert property (o_bus_valid && i_bus_done && !o_bus_req.write && !i_resync
        |=> o_rdata_valid && o_rdata == $past(i_bus_rdata)) else $error("read data lost");
    a_ack_enabled: assert property (o_ack_req |-> o_ack_en)
        else $error("ack with handshake off");
    a_err_silent: assert property (i_cmd_valid && i_cmd_err && !o_busy |=> !o_ack_req [*6])
        else $error("ack for bad command");
    a_resync_clear: assert property (i_resync && !i_cmd_valid
        |=> !o_busy && !o_bus_valid && !o_ack_req) else $error("resync did not abort");

    c_freeze: cover property (o_cpu_freeze && o_bus_valid);
    c_ack: cover property (o_ack_req);
    c_read: cover property (o_rdata_valid);
endmodule : dhc_unit_monitor

bind dhc_unit dhc_unit_monitor #(.WAIT_CYCLES(WAIT_CYCLES)) u_mon (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_cmd_valid(i_cmd_valid), .i_cmd_err(i_cmd_err),
    .i_resync(i_resync), .o_busy(o_busy), .o_rdata_valid(o_rdata_valid), .o_rdata(o_rdata),
    .o_ack_req(o_ack_req), .o_ack_en(o_ack_en), .o_cpu_freeze(o_cpu_freeze),
    .o_bus_valid(o_bus_valid), .o_bus_req(o_bus_req), .i_bus_done(i_bus_done),
    .i_bus_multi(i_bus_multi), .i_bus_rdata(i_bus_rdata));
`default_nettype wire

// *** test/dhc_bus_model.sv ***
// Purpose: System bus and memory seen by the unit
// Assumes: Same clock as the unit
// Notes:   Debug space and memory give different data
`timescale 1ns/1ps
`default_nettype none
module dhc_bus_model (
    // Clock, reset and test controls
    input  wire logic                  i_clk,
    input  wire logic                  i_nrst,
    input  wire logic                  i_stall,
    input  wire logic                  i_slow,
    // Access from the unit
    input  wire logic                  i_req_valid,
    input  wire dhc_pkg::dhc_bus_req_t i_req,
    output logic                       o_idle,
    output logic                       o_done,
    output logic                       o_multi,
    output logic [15:0]                o_rdata,
    output dhc_pkg::dhc_bus_req_t      o_last_wr
);
    import dhc_pkg::*;
    logic [1:0]  cnt_q;
    logic [15:0] val;
    // Space select changes the data seen at one address
    assign val     = i_req.addr ^ (i_req.dbg_space ? 16'h5a5a : 16'h0000);
    assign o_multi = i_req_valid & i_slow;
    assign o_done  = i_req_valid & (!i_slow | cnt_q == 2'h2);
    // Inverse when not answering, so stale data never matches
    assign o_rdata = o_done ? val : ~val;
    // Idle flag, access length and write capture
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            o_idle    <= 1'b1;
            cnt_q     <= 2'h0;
            o_last_wr <= '0;
        end
        else
        begin
            o_idle <= !i_stall;
            cnt_q  <= (i_req_valid && !o_done) ? cnt_q + 2'h1 : 2'h0;
            if (o_done && i_req.write)
                o_last_wr <= i_req;
        end
    end
endmodule : dhc_bus_model
`default_nettype wire

// *** test/debug_hw_command_unit_tb.sv ***
// Purpose: Self-checking bench for the hardware-command unit
// Assumes: Seek wait shortened to 4 cycles
// Notes:   Bench acts as serial front end and CPU
`timescale 1ns/1ps
`default_nettype none
module debug_hw_command_unit_tb;
    import dhc_pkg::*;
    logic i_clk = 1'b0, i_nrst = 1'b0, i_cmd_valid = 1'b0, i_cmd_err = 1'b0, i_resync = 1'b0;
    logic i_fw_enabled = 1'b0, i_halted = 1'b0, leave = 1'b0, stall = 1'b0, slow = 1'b0;
    logic o_busy, o_rdata_valid, o_ack_req, o_ack_en, o_halt_req, o_cpu_freeze, o_bus_valid;
    logic i_bus_idle, i_bus_done, i_bus_multi, ack_n, rd_n, frz_n;
    logic [15:0] o_rdata, i_bus_rdata, rd_val;
    dhc_cmd_t i_cmd = '0;
    dhc_bus_req_t o_bus_req, last_wr;
    int error_cnt = 0, total_checks = 0;

    dhc_unit #(.WAIT_CYCLES(4)) u_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_cmd_valid(i_cmd_valid),
        .i_cmd_err(i_cmd_err), .i_cmd(i_cmd), .i_resync(i_resync), .o_busy(o_busy),
        .o_rdata_valid(o_rdata_valid), .o_rdata(o_rdata), .o_ack_req(o_ack_req),
        .o_ack_en(o_ack_en), .i_bus_idle(i_bus_idle), .i_fw_enabled(i_fw_enabled),
        .i_halted(i_halted), .o_halt_req(o_halt_req), .o_cpu_freeze(o_cpu_freeze),
        .o_bus_valid(o_bus_valid), .o_bus_req(o_bus_req), .i_bus_done(i_bus_done),
        .i_bus_multi(i_bus_multi), .i_bus_rdata(i_bus_rdata));
    dhc_bus_model u_bus (.i_clk(i_clk), .i_nrst(i_nrst), .i_stall(stall), .i_slow(slow),
        .i_req_valid(o_bus_valid), .i_req(o_bus_req), .o_idle(i_bus_idle), .o_done(i_bus_done),
        .o_multi(i_bus_multi), .o_rdata(i_bus_rdata), .o_last_wr(last_wr));

    // Clock, and a CPU that stays halted until told to leave
    always #5 i_clk = ~i_clk;
    always @(posedge i_clk) i_halted <= (o_halt_req | i_halted) & !leave;

    task automatic end_of_test();
        $display("Checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test

    task automatic chk_val(input logic [35:0] g, input logic [35:0] e);
        total_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("Error at %0t got %h exp %h", $time, g, e);
        end
    endtask : chk_val

    task automatic chk_bit(input logic g, input logic e);
        chk_val(36'(g), 36'(e));
    endtask : chk_bit

    // One command; optional resync pulse driven rs+1 cycles after take
    task automatic run(input logic [7:0] op, input logic [15:0] a, input logic [15:0] d,
                       input logic e, input int rs);
        int n;
        int idle_n;
        @(posedge i_clk);
        i_cmd_valid <= 1'b1;
        i_cmd       <= '{op, a, d};
        i_cmd_err   <= e;
        @(posedge i_clk);
        i_cmd_valid <= 1'b0;
        i_cmd_err   <= 1'b0;
        {ack_n, rd_n, frz_n} = 3'h0;
        idle_n = 0;
        for (n = 0; n < 60 && idle_n < 4; n++)
        begin
            @(posedge i_clk);
            i_resync <= (n == rs);
            #1;
            ack_n |= o_ack_req;
            frz_n |= o_cpu_freeze;
            if (o_rdata_valid)
                rd_val = o_rdata;
            rd_n |= o_rdata_valid;
            idle_n = o_busy ? 0 : idle_n + 1;
        end
        chk_bit(o_busy, 1'b0);
    endtask : run

    task automatic t_fetch();
        logic [7:0] ops [4] = '{DHC_OP_MEM_BFETCH, DHC_OP_MEM_WFETCH, DHC_OP_DS_BFETCH,
                                DHC_OP_DS_WFETCH};
        logic ds;
        foreach (ops[k])
        begin
            run(ops[k], 16'h1230 + 16'(k), 16'h0000, 1'b0, -1);
            ds = (ops[k] == DHC_OP_DS_BFETCH) || (ops[k] == DHC_OP_DS_WFETCH);
            chk_val(36'(rd_val), 36'(16'h1230 + 16'(k) ^ (ds ? 16'h5a5a : 16'h0)));
            chk_bit(frz_n, 1'b0);
        end
    endtask : t_fetch

    task automatic t_store();
        run(DHC_OP_MEM_BSTORE, 16'h2001, 16'h00a5, 1'b0, -1);
        chk_val(36'(last_wr), {2'h2, DHC_LANE_LO, 16'h2001, 16'h00a5});
        run(DHC_OP_DS_BSTORE, 16'h2002, 16'h5a00, 1'b0, -1);
        chk_val(36'(last_wr), {2'h3, DHC_LANE_HI, 16'h2002, 16'h5a00});
        run(DHC_OP_DS_WSTORE, 16'h2004, 16'hbeef, 1'b0, -1);
        chk_val(36'(last_wr), {2'h3, DHC_LANE_BOTH, 16'h2004, 16'hbeef});
    endtask : t_store

    task automatic t_steal();
        stall = 1'b1;
        run(DHC_OP_MEM_WFETCH, 16'h0040, 16'h0000, 1'b0, -1);
        chk_bit(frz_n, 1'b1);
        chk_val(36'(rd_val), 36'h40);
        stall = 1'b0;
        slow = 1'b1;
        run(DHC_OP_MEM_BSTORE, 16'h0041, 16'h0011, 1'b0, -1);
        chk_bit(frz_n, 1'b1);
        slow = 1'b0;
    endtask : t_steal

    task automatic t_handshake();
        run(DHC_OP_ACK_ON, 16'h0000, 16'h0000, 1'b0, -1);
        chk_bit(ack_n, 1'b1);
        @(posedge i_clk) i_fw_enabled <= 1'b1;
        run(DHC_OP_HALT, 16'h0000, 16'h0000, 1'b0, -1);
        chk_bit(ack_n, 1'b1);
        chk_bit(i_halted, 1'b1);
        run(DHC_OP_MEM_BFETCH, 16'h0077, 16'h0000, 1'b0, -1);
        chk_val(36'(rd_val), 36'h77);
        run(DHC_OP_ACK_ON, 16'h0000, 16'h0000, 1'b1, -1);
        chk_bit(ack_n, 1'b0);
        leave = 1'b1;
        @(posedge i_clk) i_fw_enabled <= 1'b0;
        run(DHC_OP_HALT, 16'h0000, 16'h0000, 1'b0, -1);
        chk_bit(ack_n, 1'b0);
        run(DHC_OP_ACK_OFF, 16'h0000, 16'h0000, 1'b0, -1);
        chk_bit(ack_n, 1'b0);
        chk_bit(o_ack_en, 1'b0);
    endtask : t_handshake

    task automatic t_resync();
        run(DHC_OP_ACK_ON, 16'h0000, 16'h0000, 1'b0, -1);
        stall = 1'b1;
        run(DHC_OP_MEM_BFETCH, 16'h0101, 16'h0000, 1'b0, 1);
        chk_bit(rd_n, 1'b0);
        chk_bit(ack_n, 1'b0);
        stall = 1'b0;
        run(DHC_OP_MEM_BFETCH, 16'h0102, 16'h0000, 1'b0, -1);
        chk_val(36'(rd_val), 36'h102);
    endtask : t_resync

    initial
    begin
        repeat (5) @(posedge i_clk);
        i_nrst <= 1'b1;
        t_fetch();
        t_store();
        t_steal();
        t_handshake();
        t_resync();
        end_of_test();
    end

    // Runs take about 150 cycles; cut off well beyond
    initial
    begin
        #100000;
        error_cnt++;
        end_of_test();
    end
endmodule : debug_hw_command_unit_tb
`default_nettype wire
